// File: pc_consts.svh
// Timing and width constants shared by both ends of the channel converters.
// Assumes inclusion by bare name from the package and both design files.
`ifndef PC_CONSTS_SVH
`define PC_CONSTS_SVH
// ----------------------------------------
// Widths, stage count and constant values
// ----------------------------------------
`define PC_DATA_W 8
`define PC_SYNC_STAGES 3
`define PC_ZERO_1 1'h0
`define PC_ONE_1 1'h1
`define PC_ZERO_DATA 8'h00
`endif

// File: pc_pkg.sv
// Shared types for the channel protocol converters.
// Assumes pc_consts.svh is on the include path.
`include "pc_consts.svh"
package pc_pkg;
	typedef logic [`PC_DATA_W-1:0] pc_data_t;
	typedef enum logic [1:0] {
		PC_MODE_STRAIGHT = 2'h0,
		PC_MODE_PORTED = 2'h1,
		PC_MODE_BARE = 2'h2,
		PC_MODE_EVENT = 2'h3
	} pc_mode_t;
endpackage

// File: pc_link_if.sv
// Pad bundle between the converter and the external party.
// Assumes both ends share CLK_SYS; one direction per data bundle.
`timescale 1ns/1ns
interface pc_link_if;
	// Device to party data
	pc_pkg::pc_data_t out_data;
	// Party to device data
	pc_pkg::pc_data_t in_data;
	// Output channel handshakes: receiver ready first, transmitter ready second
	logic out_rx_rdy;
	logic out_tx_rdy;
	// Input channel handshakes
	logic in_rx_rdy;
	logic in_tx_rdy;
	// Port strobes from the program, then port and bare data both ways
	logic port_out_strobe;
	logic port_in_strobe;
	pc_pkg::pc_data_t port_out_data;
	pc_pkg::pc_data_t port_in_data;
	pc_pkg::pc_data_t bare_out_data;
	pc_pkg::pc_data_t bare_in_data;
	// Event line: acknowledge then request
	logic event_ack;
	logic event_req;
	modport device (
		output out_data, out_tx_rdy, in_rx_rdy, port_out_strobe, port_in_strobe,
		output port_out_data, bare_out_data, event_req,
		input in_data, out_rx_rdy, in_tx_rdy, port_in_data, bare_in_data, event_ack
	);
	modport party (
		input out_data, out_tx_rdy, in_rx_rdy, port_out_strobe, port_in_strobe,
		input port_out_data, bare_out_data, event_req,
		output in_data, out_rx_rdy, in_tx_rdy, port_in_data, bare_in_data, event_ack
	);
endinterface

// File: pc_device.sv
// Device end: converters between program channels and pads.
// Assumes the program side is on CLK_SYS; pads toward the party use the link.
`timescale 1ns/1ns
`include "pc_consts.svh"
module pc_device (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	pc_link_if.device LINK,
	// Straight output channel, program side
	input wire logic OUT_SEND,
	input pc_pkg::pc_data_t OUT_VALUE,
	output logic OUT_DONE,
	// Straight input channel, program side
	input wire logic IN_RECV,
	output pc_pkg::pc_data_t IN_VALUE,
	output logic IN_DONE,
	// Ported channels
	input wire logic PORT_WRITE,
	input pc_pkg::pc_data_t PORT_WVALUE,
	input wire logic PORT_READ,
	output pc_pkg::pc_data_t PORT_RVALUE,
	output logic PORT_DONE,
	// Bare ports
	input wire logic BARE_WRITE,
	input pc_pkg::pc_data_t BARE_WVALUE,
	output pc_pkg::pc_data_t BARE_RVALUE,
	// Zero-width event channel
	input wire logic EVENT_SEND,
	output logic EVENT_DONE
);
	// ----------------------------------------
	// Fire decode
	// ----------------------------------------
	// Pads are registered because top outputs come from flip-flops; the
	// handshake still completes in the cycle both lines are seen high.
	logic out_fire;
	logic in_fire;
	logic event_fire;
	assign out_fire = LINK.out_tx_rdy & LINK.out_rx_rdy;
	assign in_fire = LINK.in_rx_rdy & LINK.in_tx_rdy;
	assign event_fire = LINK.event_req & LINK.event_ack;

	// ----------------------------------------
	// Straight output converter
	// ----------------------------------------
	// Line drops after a fire; a program still holding its
	// request raises it again one cycle later.
	// Raise own handshake
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			LINK.out_tx_rdy <= `PC_ZERO_1;
		end else begin
			LINK.out_tx_rdy <= OUT_SEND & ~out_fire;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			LINK.out_data <= `PC_ZERO_DATA;
		end else begin
			LINK.out_data <= OUT_VALUE;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			OUT_DONE <= `PC_ZERO_1;
		end else begin
			OUT_DONE <= out_fire;
		end
	end

	// ----------------------------------------
	// Straight input converter
	// ----------------------------------------
	// Receiver ready is ours
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			LINK.in_rx_rdy <= `PC_ZERO_1;
		end else begin
			LINK.in_rx_rdy <= IN_RECV & ~in_fire;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			IN_VALUE <= `PC_ZERO_DATA;
		end else begin
			if (in_fire) begin
				IN_VALUE <= LINK.in_data;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			IN_DONE <= `PC_ZERO_1;
		end else begin
			IN_DONE <= in_fire;
		end
	end

	// ----------------------------------------
	// Event converter
	// ----------------------------------------
	// Zero width, handshake only
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			LINK.event_req <= `PC_ZERO_1;
		end else begin
			LINK.event_req <= EVENT_SEND & ~event_fire;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			EVENT_DONE <= `PC_ZERO_1;
		end else begin
			EVENT_DONE <= event_fire;
		end
	end

	// ----------------------------------------
	// Ported converters
	// ----------------------------------------
	// Outside taken as always ready, so the program
	// alone paces the port; nothing can stall it.
	// No incoming handshake
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			LINK.port_out_strobe <= `PC_ZERO_1;
			LINK.port_in_strobe <= `PC_ZERO_1;
		end else begin
			LINK.port_out_strobe <= PORT_WRITE;
			LINK.port_in_strobe <= PORT_READ;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			LINK.port_out_data <= `PC_ZERO_DATA;
		end else begin
			if (PORT_WRITE) begin
				LINK.port_out_data <= PORT_WVALUE;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			PORT_RVALUE <= `PC_ZERO_DATA;
		end else begin
			if (PORT_READ) begin
				PORT_RVALUE <= LINK.port_in_data;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			PORT_DONE <= `PC_ZERO_1;
		end else begin
			PORT_DONE <= PORT_WRITE | PORT_READ;
		end
	end

	// ----------------------------------------
	// Bare ports
	// ----------------------------------------
	// Data only, no strobe
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			LINK.bare_out_data <= `PC_ZERO_DATA;
		end else begin
			if (BARE_WRITE) begin
				LINK.bare_out_data <= BARE_WVALUE;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			BARE_RVALUE <= `PC_ZERO_DATA;
		end else begin
			BARE_RVALUE <= LINK.bare_in_data;
		end
	end
endmodule

// File: pc_party.sv
// External party end: answers the device's handshakes on the same clock.
// Assumes CLK_SYS is shared with the device end.
`timescale 1ns/1ns
`include "pc_consts.svh"
module pc_party (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	pc_link_if.party LINK,
	// Accept from device output channel
	input wire logic TAKE_READY,
	output pc_pkg::pc_data_t TAKE_VALUE,
	output logic TAKE_DONE,
	// Give to device input channel
	input wire logic GIVE_VALID,
	input pc_pkg::pc_data_t GIVE_VALUE,
	output logic GIVE_DONE,
	// Port and bare data toward device, port data and strobe seen from device
	input pc_pkg::pc_data_t PORT_VALUE,
	input pc_pkg::pc_data_t BARE_VALUE,
	output pc_pkg::pc_data_t PORT_SEEN,
	output logic PORT_SEEN_STROBE,
	// Event acknowledge enable
	input wire logic EVENT_ALLOW,
	output logic EVENT_SEEN
);
	logic take_fire;
	logic give_fire;
	assign take_fire = LINK.out_rx_rdy & LINK.out_tx_rdy;
	assign give_fire = LINK.in_tx_rdy & LINK.in_rx_rdy;

	// ----------------------------------------
	// Handshake lines
	// ----------------------------------------
	// Raise ready any time but the cycle after a fire
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			LINK.out_rx_rdy <= `PC_ZERO_1;
			LINK.in_tx_rdy <= `PC_ZERO_1;
			LINK.event_ack <= `PC_ZERO_1;
			LINK.in_data <= `PC_ZERO_DATA;
		end else begin
			LINK.out_rx_rdy <= TAKE_READY & ~take_fire;
			LINK.in_tx_rdy <= GIVE_VALID & ~give_fire;
			LINK.event_ack <= EVENT_ALLOW & LINK.event_req & ~LINK.event_ack;
			if (!LINK.in_tx_rdy || give_fire) begin
				LINK.in_data <= GIVE_VALUE;
			end
		end
	end

	// ----------------------------------------
	// Results
	// ----------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			TAKE_VALUE <= `PC_ZERO_DATA;
			TAKE_DONE <= `PC_ZERO_1;
			GIVE_DONE <= `PC_ZERO_1;
			PORT_SEEN <= `PC_ZERO_DATA;
			PORT_SEEN_STROBE <= `PC_ZERO_1;
			EVENT_SEEN <= `PC_ZERO_1;
			LINK.port_in_data <= `PC_ZERO_DATA;
			LINK.bare_in_data <= `PC_ZERO_DATA;
		end else begin
			TAKE_DONE <= take_fire;
			GIVE_DONE <= give_fire;
			if (take_fire) begin
				TAKE_VALUE <= LINK.out_data;
			end
			PORT_SEEN_STROBE <= LINK.port_out_strobe;
			if (LINK.port_out_strobe) begin
				PORT_SEEN <= LINK.port_out_data;
			end
			EVENT_SEEN <= LINK.event_req & LINK.event_ack;
			LINK.port_in_data <= PORT_VALUE;
			LINK.bare_in_data <= BARE_VALUE;
		end
	end
endmodule

// File: pc_link_assertions.sv
// Link checks between the two converter ends.
// Assumes the bench feeds the link signals and the shared clock.
`timescale 1ns/1ns
module pc_link_assertions (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic out_rx_rdy,
	input wire logic out_tx_rdy,
	input wire logic in_rx_rdy,
	input wire logic in_tx_rdy,
	input wire logic event_req,
	input wire logic event_ack
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	// ----
	// Handshakes
	// ----
	out_tx_drop_a: assert property (out_tx_rdy && out_rx_rdy |=> !out_tx_rdy) else $error("out tx stuck");
	out_rx_drop_a: assert property (out_tx_rdy && out_rx_rdy |=> !out_rx_rdy) else $error("out rx stuck");
	in_tx_drop_a: assert property (in_tx_rdy && in_rx_rdy |=> !in_tx_rdy) else $error("in tx stuck");
	in_rx_drop_a: assert property (in_tx_rdy && in_rx_rdy |=> !in_rx_rdy) else $error("in rx stuck");
	out_tx_hold_a: assert property (out_tx_rdy && !out_rx_rdy |=> out_tx_rdy) else $error("out tx lost");
	in_rx_hold_a: assert property (in_rx_rdy && !in_tx_rdy |=> in_rx_rdy) else $error("in rx lost");
	ack_cause_a: assert property (event_ack |-> $past(event_req)) else $error("ack without req");
	req_drop_a: assert property (event_req && event_ack |=> !event_req) else $error("req stuck");
endmodule

// File: channel_protocol_converters_tb.sv
// Bench joining both converter ends across the link.
// Assumes one 25 MHz clock; the checker watches the link.
`timescale 1ns/1ns
module channel_protocol_converters_tb;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic send = 1'h0, ready = 1'h0, wr = 1'h0, rd = 1'h0, ev = 1'h0, allow = 1'h0;
	pc_pkg::pc_data_t val = 8'h00, nval = 8'h00;
	pc_pkg::pc_data_t in_val, prv, brv, take_val, seen;
	logic out_done, in_done, port_done, ev_done, take_done, give_done, ev_seen, seen_stb;
	int fail_count = 0;
	int num_checks = 0;
	pc_link_if link ();
	pc_device u_pc_device (.CLK_SYS(clk), .RST_N(rst_n), .LINK(link), .OUT_SEND(send), .OUT_VALUE(val),
		.OUT_DONE(out_done), .IN_RECV(ready), .IN_VALUE(in_val), .IN_DONE(in_done), .PORT_WRITE(wr),
		.PORT_WVALUE(val), .PORT_READ(rd), .PORT_RVALUE(prv), .PORT_DONE(port_done), .BARE_WRITE(wr),
		.BARE_WVALUE(val), .BARE_RVALUE(brv), .EVENT_SEND(ev), .EVENT_DONE(ev_done));
	pc_party u_pc_party (.CLK_SYS(clk), .RST_N(rst_n), .LINK(link), .TAKE_READY(ready), .TAKE_VALUE(take_val),
		.TAKE_DONE(take_done), .GIVE_VALID(send), .GIVE_VALUE(nval), .GIVE_DONE(give_done), .PORT_VALUE(nval),
		.BARE_VALUE(nval), .PORT_SEEN(seen), .PORT_SEEN_STROBE(seen_stb), .EVENT_ALLOW(allow), .EVENT_SEEN(ev_seen));
	pc_link_assertions u_pc_link_assertions (.CLK_SYS(clk), .RST_N(rst_n), .out_rx_rdy(link.out_rx_rdy),
		.out_tx_rdy(link.out_tx_rdy), .in_rx_rdy(link.in_rx_rdy), .in_tx_rdy(link.in_tx_rdy),
		.event_req(link.event_req), .event_ack(link.event_ack));
	always #20 clk = ~clk;
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Both channels at once; the ready side joins lag + 1 cycles late
	task automatic t_chan(input pc_pkg::pc_data_t v, input int lag);
		int n;
		@(posedge clk);
		send <= 1'h1;
		val <= v;
		nval <= ~v;
		repeat (lag + 1) @(negedge clk);
		chk(out_done | in_done, 1'h0);
		@(posedge clk);
		ready <= 1'h1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(link.out_tx_rdy && link.out_rx_rdy) && n < 8);
		chk(link.out_data, v);
		chk({link.in_rx_rdy, link.in_tx_rdy}, 2'h3);
		chk(link.in_data, ~v);
		@(posedge clk);
		send <= 1'h0;
		ready <= 1'h0;
		@(negedge clk);
		chk({out_done, take_done, in_done, give_done}, 4'hf);
		chk(take_val, v);
		chk(in_val, ~v);
	endtask
	task automatic t_port(input pc_pkg::pc_data_t v);
		@(posedge clk);
		wr <= 1'h1;
		val <= v;
		nval <= ~v;
		@(posedge clk);
		wr <= 1'h0;
		rd <= 1'h1;
		@(negedge clk);
		chk({port_done, link.port_out_strobe}, 2'h3);
		@(posedge clk);
		rd <= 1'h0;
		// New word with no write: bare pad must keep the last one
		val <= 8'h00;
		@(negedge clk);
		chk(seen, v);
		chk(prv, ~v);
		chk({seen_stb, link.port_in_strobe}, 2'h3);
		chk(brv, ~v);
		chk(link.bare_out_data, v);
		@(negedge clk);
		chk({seen_stb, port_done}, 2'h0);
		chk(link.bare_out_data, v);
	endtask
	task automatic t_event();
		int n;
		@(posedge clk);
		ev <= 1'h1;
		repeat (4) @(negedge clk);
		chk({ev_done, link.event_ack}, 2'h0);
		@(posedge clk);
		allow <= 1'h1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (link.event_ack !== 1'h1 && n < 8);
		// Drop on the acknowledge edge, or the held request starts another
		@(posedge clk);
		ev <= 1'h0;
		allow <= 1'h0;
		@(negedge clk);
		chk(ev_seen, 1'h1);
		chk(ev_done, 1'h1);
		@(negedge clk);
		chk({ev_done, link.event_req}, 2'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		t_chan(8'h81, 0);
		t_chan(8'h3c, 3);
		t_port(8'ha5);
		t_event();
		close_out();
	end
	// Tests need well under 100 cycles
	initial begin
		#10000;
		fail_count++;
		close_out();
	end
endmodule
